// ---- verilog/arx_consts.vh ----
// Purpose: Offsets, field positions, reset values and timing counts of the receive error block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes:   Definitions only.
`ifndef ARX_CONSTS_VH
`define ARX_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARX_OFS_CTRL     4'h0
`define ARX_OFS_BAUD     4'h4
`define ARX_OFS_STATUS   4'h8
`define ARX_OFS_DATA     4'hC

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ARX_CTRL_RXEN    0
`define ARX_CTRL_PAREN   1
`define ARX_CTRL_ODD     2
`define ARX_CTRL_STOP2   3
`define ARX_CTRL_RST     4'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ARX_ST_FULL      6
`define ARX_ST_FRAME     4
`define ARX_ST_PARITY    3
`define ARX_ST_BUSY      0

// ----------------------------------------------------------------
// Timing: bit period is (divisor + 1) clock cycles
// ----------------------------------------------------------------
`define ARX_BAUD_RST     16'h0021

`endif

// ---- verilog/arx_rx_error_flags.v ----
// Purpose: Asynchronous serial receiver with framing and parity error flags behind an AHB-Lite slave.
// Assumes: One clock (mclk); rxdPin comes from the pin and is synchronised here; standbyMode is on mclk.
// Notes:   Zero-wait-state slave; read data is captured in the address phase so hrdata comes from a flop.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "arx_consts.vh"

module arx_rx_error_flags (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // System
  input  wire        standbyMode,
  // Serial line
  input  wire        rxdPin,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata
);

  // ----------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA  = 3'd2;
  localparam [2:0] ST_PAR   = 3'd3;
  localparam [2:0] ST_STOP1 = 3'd4;
  localparam [2:0] ST_STOP2 = 3'd5;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [1:0]  rxSync_ff;
  reg  [3:0]  ctrl_ff;
  reg  [15:0] baudDiv_ff;
  reg  [2:0]  state_ff;
  reg  [15:0] bitCnt_ff;
  reg  [2:0]  bitIdx_ff;
  reg  [7:0]  shift_ff;
  reg         parBit_ff;
  reg  [7:0]  rxBuffer_ff;
  reg         framingErrFlag_ff;
  reg         parityErrFlag_ff;
  reg         receiveFullFlag_ff;
  reg  [2:0]  seenOne_ff;
  reg         dpWrite_ff;
  reg  [3:0]  dpAddr_ff;
  reg  [31:0] rdValue;
  wire        rxLine;
  wire        rxEnable;
  wire        addrPhase;
  wire        stWrite;
  wire        bitDone;
  wire        frameEnd;
  wire        frameBad;
  wire        parityBad;
  wire        rxBlocked;
  wire        setFrame;
  wire        setParity;
  wire        setFull;
  wire        clrFrame;
  wire        clrParity;
  wire        clrFull;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One step of the bit-time down counter; callers reload it at zero.
  function [15:0] countDown;
    input [15:0] cnt;
    begin
      countDown = cnt - 16'h0001;
    end
  endfunction

  // True when a register offset selects the status register.
  function isStatus;
    input [3:0] ofs;
    begin
      isStatus = (ofs == `ARX_OFS_STATUS);
    end
  endfunction

  // True when data plus parity bit disagree with the selected parity sense.
  function parityMismatch;
    input [7:0] data;
    input       par;
    input       odd;
    begin
      parityMismatch = ((^data ^ par) != odd);
    end
  endfunction

  assign rxLine    = rxSync_ff[1];
  assign rxEnable  = ctrl_ff[`ARX_CTRL_RXEN];
  assign addrPhase = hsel & htrans[1] & hready;
  assign stWrite   = dpWrite_ff & isStatus(dpAddr_ff);
  assign bitDone   = (bitCnt_ff == 16'h0000);

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Reset to the idle level so that no false start edge follows reset.
      // Only the second stage feeds the receiver logic.
      rxSync_ff <= 2'b11;
    end else begin
      rxSync_ff <= {rxSync_ff[0], rxdPin};
    end
  end

  // ----------------------------------------------------------------
  // Frame checks at the first stop bit
  // ----------------------------------------------------------------
  // The second stop bit never reaches this check, so its value is don't-care.
  assign frameEnd  = (state_ff == ST_STOP1) & bitDone & rxEnable;
  assign frameBad  = frameEnd & ~rxLine;
  assign parityBad = frameEnd & ctrl_ff[`ARX_CTRL_PAREN] &
                     parityMismatch(shift_ff, parBit_ff, ctrl_ff[`ARX_CTRL_ODD]);

  // A pending error halts the receiver until software clears it.
  assign rxBlocked = framingErrFlag_ff | parityErrFlag_ff | standbyMode;

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      bitCnt_ff <= 16'h0000;
      bitIdx_ff <= 3'd0;
      shift_ff  <= 8'h00;
      parBit_ff <= 1'b0;
    end else if (!rxEnable || standbyMode) begin
      // Dropping receive enable aborts a frame; the flags are left as they are.
      // Standby likewise parks the receiver in idle.
      state_ff  <= ST_IDLE;
      bitCnt_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (!rxBlocked && !rxLine) begin
            state_ff  <= ST_START;
            bitCnt_ff <= {1'b0, baudDiv_ff[15:1]};
          end
        end
        ST_START: begin
          if (!bitDone) begin
            bitCnt_ff <= countDown(bitCnt_ff);
          end else if (rxLine) begin
            state_ff <= ST_IDLE;
          end else begin
            state_ff  <= ST_DATA;
            bitCnt_ff <= baudDiv_ff;
            bitIdx_ff <= 3'd0;
          end
        end
        ST_DATA: begin
          if (!bitDone) begin
            bitCnt_ff <= countDown(bitCnt_ff);
          end else begin
            shift_ff  <= {rxLine, shift_ff[7:1]};
            bitCnt_ff <= baudDiv_ff;
            bitIdx_ff <= bitIdx_ff + 3'd1;
            if (bitIdx_ff == 3'd7) begin
              state_ff <= ctrl_ff[`ARX_CTRL_PAREN] ? ST_PAR : ST_STOP1;
            end
          end
        end
        ST_PAR: begin
          if (!bitDone) begin
            bitCnt_ff <= countDown(bitCnt_ff);
          end else begin
            parBit_ff <= rxLine;
            bitCnt_ff <= baudDiv_ff;
            state_ff  <= ST_STOP1;
          end
        end
        ST_STOP1: begin
          if (!bitDone) begin
            bitCnt_ff <= countDown(bitCnt_ff);
          end else if (ctrl_ff[`ARX_CTRL_STOP2]) begin
            bitCnt_ff <= baudDiv_ff;
            state_ff  <= ST_STOP2;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        ST_STOP2: begin
          if (!bitDone) begin
            bitCnt_ff <= countDown(bitCnt_ff);
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and status flags
  // ----------------------------------------------------------------
  assign setFrame  = frameBad;
  assign setParity = parityBad;
  assign setFull   = frameEnd & ~frameBad & ~parityBad;
  // Clearing needs a prior read that returned 1 and a written 0.
  assign clrFrame  = stWrite & ~hwdata[`ARX_ST_FRAME]  & seenOne_ff[2];
  assign clrParity = stWrite & ~hwdata[`ARX_ST_PARITY] & seenOne_ff[1];
  assign clrFull   = stWrite & ~hwdata[`ARX_ST_FULL]   & seenOne_ff[0];

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxBuffer_ff <= 8'h00;
    end else if (frameEnd) begin
      // The buffer takes every finished frame, good or bad.
      rxBuffer_ff <= shift_ff;
    end
  end

  // Flags are untouched by the receive enable bit; only the terms below move them.
  // A set in the same cycle as a clear wins.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      framingErrFlag_ff  <= 1'b0;
      parityErrFlag_ff   <= 1'b0;
      receiveFullFlag_ff <= 1'b0;
      seenOne_ff         <= 3'b000;
    end else if (standbyMode) begin
      framingErrFlag_ff  <= 1'b0;
      parityErrFlag_ff   <= 1'b0;
      receiveFullFlag_ff <= 1'b0;
      seenOne_ff         <= 3'b000;
    end else begin
      if (setFrame) begin
        framingErrFlag_ff <= 1'b1;
      end else if (clrFrame) begin
        framingErrFlag_ff <= 1'b0;
      end
      if (setParity) begin
        parityErrFlag_ff <= 1'b1;
      end else if (clrParity) begin
        parityErrFlag_ff <= 1'b0;
      end
      if (setFull) begin
        receiveFullFlag_ff <= 1'b1;
      end else if (clrFull) begin
        receiveFullFlag_ff <= 1'b0;
      end
      // A read and a clear in one cycle must not leave a stale mark behind.
      seenOne_ff <= (seenOne_ff | ({3{addrPhase & ~hwrite & isStatus(haddr[3:0])}} &
                    {framingErrFlag_ff, parityErrFlag_ff, receiveFullFlag_ff})) & ~{clrFrame, clrParity, clrFull};
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always @* begin
    rdValue = 32'h0000_0000;
    case (haddr[3:0])
      `ARX_OFS_CTRL: begin
        rdValue[3:0] = ctrl_ff;
      end
      `ARX_OFS_BAUD: begin
        rdValue[15:0] = baudDiv_ff;
      end
      `ARX_OFS_STATUS: begin
        rdValue[`ARX_ST_FULL]   = receiveFullFlag_ff;
        rdValue[`ARX_ST_FRAME]  = framingErrFlag_ff;
        rdValue[`ARX_ST_PARITY] = parityErrFlag_ff;
        rdValue[`ARX_ST_BUSY]   = (state_ff != ST_IDLE);
      end
      `ARX_OFS_DATA: begin
        rdValue[7:0] = rxBuffer_ff;
      end
      default: begin
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      dpWrite_ff <= 1'b0;
      dpAddr_ff  <= 4'h0;
      ctrl_ff    <= `ARX_CTRL_RST;
      baudDiv_ff <= `ARX_BAUD_RST;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      // Writes land at the end of their data phase, when hwdata stands.
      // Reads are sampled in the address phase, so hrdata comes straight from a flop.
      dpWrite_ff <= addrPhase & hwrite;
      if (addrPhase) begin
        dpAddr_ff <= haddr[3:0];
        if (!hwrite) begin
          hrdata <= rdValue;
        end
      end
      if (dpWrite_ff && dpAddr_ff == `ARX_OFS_CTRL) begin
        ctrl_ff <= hwdata[3:0];
      end
      if (dpWrite_ff && dpAddr_ff == `ARX_OFS_BAUD) begin
        baudDiv_ff <= hwdata[15:0];
      end
    end
  end

endmodule // arx_rx_error_flags
`default_nettype wire

// ---- tb/arx_rx_assertions.sv ----
// Purpose: Bus-visible checks on the receive error flags.
// Assumes: One mclk domain; nrst is active low.
// Notes:   The flags are seen only through STATUS reads at offset 0x8.
`timescale 1ns/1ps
`default_nettype none
module arx_rx_assertions (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // System and serial line
  input wire logic        standbyMode,
  input wire logic        rxdPin,
  // AHB-Lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  wire logic stAp = hsel && htrans[1] && hready && haddr[3:0] == 4'h8;
  wire logic rdS  = stAp && !hwrite;
  wire logic wrS  = stAp && hwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence sSeen(int b);
    rdS ##1 hrdata[b];
  endsequence
  sequence sWr(int b, bit v);
    wrS ##1 hwdata[b] == v;
  endsequence
  // Only a STATUS write or standby may lower a flag that a read has shown as 1.
  property pKeep(int b);
    sSeen(b) ##1 (!wrS && !standbyMode) [*3] ##1 rdS |=> hrdata[b];
  endproperty
  property pWr(int b, bit v);
    sSeen(b) ##1 sWr(b, v) ##2 rdS |=> hrdata[b] == v;
  endproperty
  a_keep_frame: assert property (pKeep(4)) else $error("framing flag lost");
  a_keep_par: assert property (pKeep(3)) else $error("parity flag lost");
  a_one_frame: assert property (pWr(4, 1'b1)) else $error("framing flag cleared by 1");
  a_one_par: assert property (pWr(3, 1'b1)) else $error("parity flag cleared by 1");
  a_clear_frame: assert property (pWr(4, 1'b0)) else $error("framing flag not cleared");
  a_clear_par: assert property (pWr(3, 1'b0)) else $error("parity flag not cleared");
  a_stby_clear: assert property (standbyMode && $past(standbyMode) && rdS |=> hrdata[4:3] == 2'b00)
    else $error("flag survives standby");
  a_bus_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule // arx_rx_assertions
bind arx_rx_error_flags arx_rx_assertions u_chk (.mclk(mclk), .nrst(nrst), .standbyMode(standbyMode),
  .rxdPin(rxdPin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// ---- tb/arx_tx_model.sv ----
// Purpose: Remote asynchronous transmitter driving the receive line.
// Assumes: Bit time of BITC mclk cycles, matching the divisor the bench writes.
// Notes:   The line rests high between frames, as an idle line does.
`timescale 1ns/1ps
`default_nettype none
module arx_tx_model #(parameter int BITC = 4) (
  // Clock
  input  wire logic mclk,
  // Serial line
  output var  logic txd
);
  initial txd = 1'b1;
  // Start, eight data bits LSB first, optional parity, one or two stops.
  // The second stop bit carries b2, so the receiver's disregard of it is exercised.
  task automatic send(input logic [7:0] d, input bit pe, od, s2, bp, bs, b2);
    bit q[$];
    q.push_back(1'b0);
    for (int i = 0; i < 8; i++) q.push_back(d[i]);
    if (pe) q.push_back(^d ^ od ^ bp);
    q.push_back(!bs);
    if (s2) q.push_back(b2);
    foreach (q[i]) begin
      txd <= q[i];
      repeat (BITC) @(posedge mclk);
    end
    txd <= 1'b1;
  endtask
endmodule // arx_tx_model
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the receive error flags.
// Assumes: Divisor 3 gives four clocks per bit.
// Notes:   A small integer model predicts STATUS and DATA.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk, nrst, standbyMode, hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  wire logic   hreadyout, hresp, rxd;
  int          fails, numChecks, expF, expP, expFull, rxEn, pe, od, s2, seen, m;
  logic [7:0]  expData;
  arx_rx_error_flags u_dut (.mclk(mclk), .nrst(nrst), .standbyMode(standbyMode), .rxdPin(rxd),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  arx_tx_model #(.BITC(4)) u_tx (.mclk(mclk), .txd(rxd));
  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A write leaves one idle cycle so a following read sees the new value.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h000_0000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    if (wr) @(posedge mclk);
  endtask
  task automatic rdSt();
    seen = {25'd0, expFull[0], 1'b0, expF[0], expP[0], 3'd0};
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(r, seen[31:0]);
  endtask
  task automatic wrSt(input logic [31:0] v);
    bus(1'b1, 4'h8, v);
    if (seen[4] && !v[4]) expF = 0;
    if (seen[3] && !v[3]) expP = 0;
    if (seen[6] && !v[6]) expFull = 0;
    seen = seen & v;
  endtask
  task automatic setCtrl(input bit en, p, o, s);
    rxEn = en;
    pe = p;
    od = o;
    s2 = s;
    bus(1'b1, 4'h0, {28'h000_0000, s, o, p, en});
  endtask
  task automatic frame(input logic [7:0] d, input bit bp, bs);
    u_tx.send(d, pe[0], od[0], s2[0], bp, bs, 1'($urandom));
    repeat (8) @(posedge mclk);
    if (rxEn != 0 && expF == 0 && expP == 0) begin
      expData = d;
      if (bs) expF = 1;
      else if (pe != 0 && bp) expP = 1;
      else expFull = 1;
    end
    rdSt();
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(r, {24'h00_0000, expData});
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end
  initial begin
    {nrst, standbyMode, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {expF, expP, expFull, rxEn, pe, od, s2, seen, expData} = '0;
    void'($urandom(50889));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    rdSt();
    bus(1'b1, 4'h4, 32'h0000_0003);
    for (m = 0; m < 8; m++) begin
      setCtrl(1'b1, m[0], m[1], m[2]);
      frame(8'($urandom), 1'b0, 1'b0);
      rdSt();
      wrSt(32'h0000_0000);
    end
    $display("good frames done");
    for (m = 0; m < 3; m++) begin
      setCtrl(1'b1, m > 0, m == 2, 1'b0);
      frame(8'($urandom), m > 0, m == 0);
      frame(8'($urandom), 1'b0, 1'b0);
      rdSt();
      setCtrl(1'b0, m > 0, m == 2, 1'b0);
      rdSt();
      wrSt(32'h0000_0058);
      rdSt();
      wrSt(32'h0000_0000);
      rdSt();
    end
    $display("error frames done");
    setCtrl(1'b1, 1'b0, 1'b0, 1'b0);
    frame(8'($urandom), 1'b0, 1'b1);
    standbyMode <= 1'b1;
    @(posedge mclk);
    {expF, expP, expFull} = '0;
    rdSt();
    standbyMode <= 1'b0;
    $display("standby done");
    final_report();
  end
endmodule // tb
`default_nettype wire
